/* File: hw/led_pulser.sv */
// counted blink generator for the mode and status leds
`timescale 1ns/100ps
`include "pin_access_defines.svh"
module led_pulser
  import pin_access_pkg::*;
#(
  parameter logic [31:0] BLINK_CYCLES = 32'(`BLINK_CYC)
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [8:0] counts,
  output logic blink,
  output logic busy
);
  logic [31:0] timer_reg;
  logic [8:0] left_reg;
  logic [3:0] pulses_reg;
  logic phase_reg;
  wire logic tick = (timer_reg == 32'h0000_0000);
  wire logic [3:0] firstCount = {1'b0, counts[2:0]};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_reg <= 32'h0000_0000;
      left_reg <= 9'h000;
      pulses_reg <= 4'h0;
      phase_reg <= 1'b0;
      busy <= 1'b0;
      blink <= 1'b0;
    end else if (start) begin
      timer_reg <= BLINK_CYCLES;
      left_reg <= {3'h0, counts[8:3]};
      pulses_reg <= firstCount;
      phase_reg <= 1'b0;
      busy <= 1'b1;
      blink <= 1'b0;
    end else if (busy) begin
      timer_reg <= tick ? BLINK_CYCLES : timer_reg - 32'h0000_0001;
      if (tick) begin
        // pulses then an off gap per digit; pause reads as digit boundary
        if (pulses_reg != 4'h0) begin
          phase_reg <= ~phase_reg;
          blink <= ~phase_reg;
          if (phase_reg)
            pulses_reg <= pulses_reg - 4'h1;
        end else if (left_reg != 9'h000) begin
          pulses_reg <= {1'b0, left_reg[2:0]};
          left_reg <= {3'h0, left_reg[8:3]};
          blink <= 1'b0;
        end else begin
          busy <= 1'b0;
          blink <= 1'b0;
        end
      end
    end
  end
endmodule

/* File: hw/pin_access_ctrl.sv */
// keypad pin access controller with boot sequence and default tables
`timescale 1ns/100ps
`include "pin_access_defines.svh"
module pin_access_ctrl
  import pin_access_pkg::*;
#(
  parameter logic [35:0] IDLE_CYCLES = 36'(`IDLE_TIMEOUT_CYC),
  parameter logic [31:0] OFF_CYCLES = 32'(`SWITCH_OFF_CYC),
  parameter logic [31:0] BLINK_CYCLES = 32'(`BLINK_CYC)
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic symValid,
  input wire logic [3:0] symbol,
  output logic modeLed,
  output logic statusLed,
  output logic controlMode,
  output logic bootDone,
  output logic bankSelect,
  output switch_cmd_t switchCmd
);
  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  logic [4:0] symSync1_reg, symSync2_reg;
  logic symValidLast_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      symSync1_reg <= 5'h00;
      symSync2_reg <= 5'h00;
      symValidLast_reg <= 1'b0;
    end else begin
      symSync1_reg <= {symValid, symbol};
      symSync2_reg <= symSync1_reg;
      symValidLast_reg <= symSync2_reg[4];
    end
  end
  wire logic symStrobe = symSync2_reg[4] & ~symValidLast_reg;
  wire logic [3:0] sym = symSync2_reg[3:0];

  // ----------------------------------------------------------------
  // tables and state
  // ----------------------------------------------------------------
  entry_t modTable [`TABLE_ENTRIES];
  entry_t slotTable [`TABLE_ENTRIES];
  logic [15:0] pin_reg, pendingPin_reg, savedPin_reg;
  logic pendingValid_reg, pinDirty_reg, newPinLast_reg;
  logic [3:0] digits_reg [`MAX_DIGITS];
  logic [3:0] count_reg;
  logic collecting_reg;
  logic [35:0] idle_reg;
  logic resetArmed_reg, keyShown_reg;
  logic [8:0] key_reg, lfsr_reg;
  boot_t boot_reg;
  logic [6:0] bootIdx_reg;
  logic [31:0] bootTimer_reg;
  logic [8:0] pulseCounts;
  logic pulseStart, pulseBlink, pulseBusy;
  function automatic logic [7:0] two_digit(input logic [3:0] hi,
                                           input logic [3:0] lo);
    two_digit = 8'(hi * 4'hA + {4'h0, lo});
  endfunction
  // house codes 01..16 stand for A..P, stored as binary numbers
  function automatic logic valid_house(input logic [7:0] h);
    valid_house = (h >= 8'h01) && (h <= 8'h10);
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire logic enterNow = symStrobe && sym == `SYM_ENTER && collecting_reg;
  wire logic [3:0] cmd = digits_reg[0];
  wire logic [15:0] fourDigits = {digits_reg[1], digits_reg[2],
                                  digits_reg[3], digits_reg[4]};
  wire logic isPin = enterNow && cmd == `CMD_PIN && count_reg == 4'h5;
  wire logic isResetBegin = enterNow && cmd == `CMD_SAVE &&
                            count_reg == 4'h2 && digits_reg[1] == 4'h1;
  wire logic isKeyGen = enterNow && cmd == `CMD_SAVE && count_reg == 4'h3
                        && digits_reg[1] == 4'h1 && digits_reg[2] == 4'h1;
  wire logic [8:0] keyDigits = {digits_reg[4][2:0], digits_reg[3][2:0],
                                digits_reg[2][2:0]};
  wire logic isResetKey = enterNow && cmd == `CMD_SAVE &&
                          count_reg == 4'h5 && digits_reg[1] == 4'h1;
  wire logic ctrlCmd = enterNow && controlMode;
  wire logic isNewPin = ctrlCmd && cmd == `CMD_NEWPIN && count_reg == 4'h5;
  wire logic isConfirm = ctrlCmd && cmd == `CMD_CONFIRM && count_reg == 4'h5;
  wire logic isSave = ctrlCmd && cmd == `CMD_SAVE && count_reg == 4'h1;
  wire logic isCancel = ctrlCmd && cmd == `CMD_SAVE && count_reg == 4'h2
                        && digits_reg[1] == 4'h0;
  wire logic [7:0] mapIdx = two_digit(digits_reg[1], digits_reg[2]);
  wire logic [7:0] mapHouse = two_digit(digits_reg[3], digits_reg[4]);
  wire logic [7:0] mapUnit = two_digit(digits_reg[5], digits_reg[6]);
  wire logic mapOk = count_reg == 4'h7 && mapIdx != 8'h00 &&
                     mapIdx < 8'(`TABLE_ENTRIES) &&
                     ((mapHouse == 8'h00 && mapUnit == 8'h00) ||
                      (valid_house(mapHouse) && mapUnit != 8'h00));
  wire logic isModMap = ctrlCmd && cmd == `CMD_MODMAP && mapOk;
  wire logic isSlotMap = ctrlCmd && cmd == `CMD_SLOTMAP && mapOk;
  wire logic isDirect = ctrlCmd && cmd == `CMD_SWITCH && count_reg == 4'h6
                        && valid_house(mapIdx);
  wire logic isShort = ctrlCmd && cmd == `CMD_SWITCH &&
                       (count_reg == 4'h3 || count_reg == 4'h4);
  wire logic [7:0] shortIdx = (count_reg == 4'h3) ? {4'h0, digits_reg[1]}
                              : mapIdx;
  wire logic [3:0] shortOpt = (count_reg == 4'h3) ? digits_reg[2]
                              : digits_reg[3];
  wire logic [3:0] directOpt = digits_reg[5];
  wire entry_t shortEntry = modTable[7'(shortIdx)];
  wire entry_t bootEntry = slotTable[bootIdx_reg];
  wire logic keyMatch = resetArmed_reg && keyShown_reg &&
                        keyDigits == key_reg;
  wire logic [8:0] nextKey = {3'(lfsr_reg[8:6] % 3'h5 + 3'h1),
                              3'(lfsr_reg[5:3] % 3'h5 + 3'h1),
                              3'(lfsr_reg[2:0] % 3'h5 + 3'h1)};

  // ----------------------------------------------------------------
  // digit collection
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      collecting_reg <= 1'b0;
      count_reg <= 4'h0;
      for (int i = 0; i < `MAX_DIGITS; i++)
        digits_reg[i] <= 4'h0;
    end else if (symStrobe && boot_reg == BOOT_DONE) begin
      if (sym == `SYM_START) begin
        collecting_reg <= 1'b1;
        count_reg <= 4'h0;
      end else if (sym == `SYM_ENTER) begin
        collecting_reg <= 1'b0;
      end else if (collecting_reg && sym <= 4'h9) begin
        if (count_reg < 4'(`MAX_DIGITS)) begin
          digits_reg[3'(count_reg)] <= sym;
          count_reg <= count_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin, control mode and reset key
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_reg <= `FACTORY_PIN;
      savedPin_reg <= `FACTORY_PIN;
      pendingPin_reg <= 16'h0000;
      pendingValid_reg <= 1'b0;
      pinDirty_reg <= 1'b0;
      newPinLast_reg <= 1'b0;
      controlMode <= 1'b0;
      idle_reg <= 36'h0_0000_0000;
      resetArmed_reg <= 1'b0;
      keyShown_reg <= 1'b0;
      key_reg <= 9'h000;
      lfsr_reg <= 9'h001;
    end else begin
      lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
      if (enterNow)
        newPinLast_reg <= isNewPin;
      if (isPin && fourDigits == savedPin_reg) begin
        controlMode <= 1'b1;
        idle_reg <= 36'h0_0000_0000;
      end else if (isSave || isCancel) begin
        controlMode <= 1'b0;
      end else if (controlMode) begin
        if (enterNow)
          idle_reg <= 36'h0_0000_0000;
        else if (idle_reg >= IDLE_CYCLES - 36'h0_0000_0001)
          controlMode <= 1'b0;
        else
          idle_reg <= idle_reg + 36'h0_0000_0001;
      end
      if (isNewPin) begin
        pendingPin_reg <= fourDigits;
        pendingValid_reg <= 1'b1;
      end
      // a confirm only counts straight after a new pin, digits equal
      if (isConfirm && newPinLast_reg && pendingValid_reg &&
          fourDigits == pendingPin_reg) begin
        pin_reg <= pendingPin_reg;
        pinDirty_reg <= 1'b1;
      end
      if (isSave && pinDirty_reg) begin
        savedPin_reg <= pin_reg;
        pinDirty_reg <= 1'b0;
        pendingValid_reg <= 1'b0;
      end else if (isCancel) begin
        pin_reg <= savedPin_reg;
        pinDirty_reg <= 1'b0;
        pendingValid_reg <= 1'b0;
      end
      if (isResetBegin) begin
        resetArmed_reg <= 1'b1;
        keyShown_reg <= 1'b0;
      end else if (isKeyGen && resetArmed_reg) begin
        key_reg <= nextKey;
        keyShown_reg <= 1'b1;
      end else if (isResetKey) begin
        if (keyMatch) begin
          pin_reg <= `FACTORY_PIN;
          savedPin_reg <= `FACTORY_PIN;
        end
        resetArmed_reg <= 1'b0;
        keyShown_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // tables and defaults
  // ----------------------------------------------------------------
  // reset-loaded register tables; a memory would lose the defaults
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `TABLE_ENTRIES; i++) begin
        if (i >= 1 && i <= `DEF_MODULES) begin
          modTable[i] <= {`DEF_HOUSE, 8'(i)};
          slotTable[i] <= {`DEF_HOUSE,
                           8'(i + `DEF_SLOT_UNIT0 - 1)};
        end else begin
          modTable[i] <= `UNDEF_ENTRY;
          slotTable[i] <= `UNDEF_ENTRY;
        end
      end
    end else begin
      if (isModMap)
        modTable[7'(mapIdx)] <= {mapHouse, mapUnit};
      if (isSlotMap)
        slotTable[7'(mapIdx)] <= {mapHouse, mapUnit};
    end
  end

  // ----------------------------------------------------------------
  // power-up sequence and switch commands
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_reg <= BOOT_BLINK;
      bootIdx_reg <= 7'h01;
      bootTimer_reg <= 32'h0000_0000;
      bootDone <= 1'b0;
      bankSelect <= 1'b0;
      switchCmd <= '0;
    end else begin
      switchCmd <= '0;
      unique case (boot_reg)
        BOOT_BLINK: begin
          if (!pulseBusy && bootTimer_reg != 32'h0000_0000)
            boot_reg <= BOOT_READ;
          bootTimer_reg <= 32'h0000_0001;
        end
        BOOT_READ: begin
          bootTimer_reg <= 32'h0000_0000;
          boot_reg <= BOOT_OFF;
        end
        BOOT_OFF: begin
          if (bootTimer_reg != 32'h0000_0000) begin
            bootTimer_reg <= bootTimer_reg - 32'h0000_0001;
          end else if (bootIdx_reg == 7'(`TABLE_ENTRIES)) begin
            boot_reg <= BOOT_BANK;
          end else begin
            bootIdx_reg <= bootIdx_reg + 7'h01;
            if (bootEntry != `UNDEF_ENTRY) begin
              switchCmd <= {1'b1, bootEntry.house, bootEntry.unit, 1'b0};
              bootTimer_reg <= OFF_CYCLES;
            end
          end
        end
        BOOT_BANK: begin
          bankSelect <= 1'b1;
          boot_reg <= BOOT_ON;
        end
        BOOT_ON: begin
          if (slotTable[1] != `UNDEF_ENTRY)
            switchCmd <= {1'b1, slotTable[1].house, slotTable[1].unit,
                          1'b1};
          boot_reg <= BOOT_DONE;
          bootDone <= 1'b1;
        end
        BOOT_DONE: begin
          if (isDirect && directOpt <= 4'h1)
            switchCmd <= {1'b1, mapIdx, mapHouse, directOpt[0]};
          else if (isShort && shortOpt <= 4'h1 &&
                   shortEntry != `UNDEF_ENTRY)
            switchCmd <= {1'b1, shortEntry.house, shortEntry.unit,
                          shortOpt[0]};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // leds
  // ----------------------------------------------------------------
  assign pulseStart = (boot_reg == BOOT_BLINK &&
                       bootTimer_reg == 32'h0000_0000) ||
                      (isKeyGen && resetArmed_reg);
  assign pulseCounts = (boot_reg == BOOT_BLINK) ? 9'h001 : nextKey;

  led_pulser #(.BLINK_CYCLES(BLINK_CYCLES)) pulser (
    .core_clk(core_clk),
    .rst(rst),
    .start(pulseStart),
    .counts(pulseCounts),
    .blink(pulseBlink),
    .busy(pulseBusy)
  );

  wire logic bootBlinking = boot_reg == BOOT_BLINK;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      modeLed <= 1'b0;
      statusLed <= 1'b0;
    end else begin
      // key blinking overrides the steady control mode level
      modeLed <= pulseBusy ? pulseBlink : controlMode;
      statusLed <= bootBlinking ? pulseBlink
                   : (controlMode && collecting_reg && lfsr_reg[0]);
    end
  end
endmodule

/* File: hw/pin_access_defines.svh */
// constants for the keypad pin access controller
`ifndef PIN_ACCESS_DEFINES_SVH
`define PIN_ACCESS_DEFINES_SVH
`define CLK_HZ 40000000
`define IDLE_TIMEOUT_SEC 300
`define IDLE_TIMEOUT_CYC (64'(`IDLE_TIMEOUT_SEC) * 64'(`CLK_HZ))
`define SWITCH_OFF_MS 1000
`define SWITCH_OFF_CYC ((`CLK_HZ / 1000) * `SWITCH_OFF_MS)
`define BLINK_MS 250
`define BLINK_CYC ((`CLK_HZ / 1000) * `BLINK_MS)
`define FACTORY_PIN 16'h1111
`define DEF_HOUSE 8'h01
`define UNDEF_ENTRY 16'h0000
`define TABLE_ENTRIES 100
`define DEF_MODULES 8
`define DEF_SLOT_UNIT0 9
`define SYM_START 4'hA
`define SYM_ENTER 4'hB
`define CMD_PIN 4'h1
`define CMD_SWITCH 4'h2
`define CMD_NEWPIN 4'h5
`define CMD_CONFIRM 4'h6
`define CMD_SLOTMAP 4'h7
`define CMD_MODMAP 4'h8
`define CMD_SAVE 4'h9
`define MAX_DIGITS 8
`define KEY_DIGIT_MAX 3'h5
`endif

/* File: hw/pin_access_pkg.sv */
// types for the keypad pin access controller
package pin_access_pkg;
  typedef struct packed {
    logic [7:0] house;
    logic [7:0] unit;
  } entry_t;
  typedef struct packed {
    logic valid;
    logic [7:0] house;
    logic [7:0] unit;
    logic on;
  } switch_cmd_t;
  typedef enum logic [2:0] {
    BOOT_BLINK, BOOT_READ, BOOT_OFF, BOOT_BANK, BOOT_ON, BOOT_DONE
  } boot_t;
endpackage

/* File: testbench/keypad_model.sv */
// keypad digit sender standing in for the remote user
`timescale 1ns/100ps
`include "pin_access_defines.svh"
module keypad_model (
  input wire logic core_clk,
  output logic symValid,
  output logic [3:0] symbol
);
  int seed = 40931;

  initial begin
    symValid = 1'b0;
    symbol = 4'h0;
  end

  // ----------------------------------------
  // one symbol: held for 8 cycles, then noise
  // ----------------------------------------
  // symbol is noise while the strobe is low so no stale value can help
  task automatic pulse(input logic [3:0] code);
    int gap;
    gap = 4 + ({$random(seed)} % 4);
    @(posedge core_clk);
    #1 symbol = code;
    symValid = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 symValid = 1'b0;
    repeat (gap) begin
      symbol = 4'($random(seed));
      @(posedge core_clk);
      #1;
    end
  endtask

  // whole command string, start and enter symbols included
  task automatic send(input string s);
    logic [3:0] code;
    for (int i = 0; i < s.len(); i++) begin
      if (s[i] == "*") begin
        code = `SYM_START;
      end else if (s[i] == "#") begin
        code = `SYM_ENTER;
      end else begin
        code = 4'(s[i] - "0");
      end
      pulse(code);
    end
  endtask
endmodule

/* File: testbench/pin_access_monitor.sv */
// concurrent checks on the pin access controller ports
`timescale 1ns/100ps
`include "pin_access_defines.svh"
module pin_access_monitor
  import pin_access_pkg::*;
#(
  parameter logic [35:0] IDLE_CYCLES = 36'h0_0000_03E8,
  parameter logic [31:0] OFF_CYCLES = 32'h0000_0032
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic symValid,
  input wire logic [3:0] symbol,
  input wire logic modeLed,
  input wire logic statusLed,
  input wire logic controlMode,
  input wire logic bootDone,
  input wire logic bankSelect,
  input wire switch_cmd_t switchCmd
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [31:0] idleCnt_reg;
  logic [31:0] gapCnt_reg;
  logic prevOff_reg;
  logic symPrev_reg;
  wire logic symRise = symValid && !symPrev_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idleCnt_reg <= 32'h0000_0000;
      gapCnt_reg <= 32'h0000_0000;
      prevOff_reg <= 1'b0;
      symPrev_reg <= 1'b0;
    end else begin
      symPrev_reg <= symValid;
      idleCnt_reg <= (!controlMode || symRise) ? 32'h0 : idleCnt_reg + 1;
      gapCnt_reg <= switchCmd.valid ? 32'h0 : gapCnt_reg + 1;
      if (switchCmd.valid) begin
        prevOff_reg <= !switchCmd.on && !bootDone;
      end
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_enter_key;
    symValid && symbol == `SYM_ENTER;
  endsequence
  sequence s_boot_off;
    switchCmd.valid && !switchCmd.on && !bootDone;
  endsequence

  property p_enter_on_key;
    $rose(controlMode) |-> s_enter_key;
  endproperty
  property p_valid_pulse;
    switchCmd.valid |=> !switchCmd.valid;
  endproperty
  property p_led_mode;
    controlMode && $past(controlMode) |-> modeLed;
  endproperty
  property p_no_cmd;
    bootDone && $past(bootDone) && !controlMode && !$past(controlMode)
      |-> !switchCmd.valid;
  endproperty
  property p_boot_off;
    s_boot_off |-> !bankSelect && switchCmd.house == `DEF_HOUSE
      && switchCmd.unit >= 8'h09 && switchCmd.unit <= 8'h10;
  endproperty
  property p_boot_on;
    switchCmd.valid && switchCmd.on && $rose(bootDone) |-> bankSelect
      && switchCmd.house == 8'h01 && switchCmd.unit == 8'h09;
  endproperty
  property p_boot_bank;
    $rose(bootDone) |-> bankSelect && $past(bankSelect);
  endproperty
  property p_off_gap;
    s_boot_off and prevOff_reg |-> gapCnt_reg >= OFF_CYCLES - 1;
  endproperty
  property p_idle;
    idleCnt_reg > IDLE_CYCLES + 16 |-> !controlMode;
  endproperty

  a_enter_on_key: assert property (p_enter_on_key) else $error("mode w/o enter");
  a_valid_pulse: assert property (p_valid_pulse) else $error("long strobe");
  a_led_mode: assert property (p_led_mode) else $error("mode led off");
  a_no_cmd: assert property (p_no_cmd) else $error("cmd outside mode");
  a_boot_off: assert property (p_boot_off) else $error("bad boot off");
  a_boot_on: assert property (p_boot_on) else $error("bad boot on");
  a_boot_bank: assert property (p_boot_bank) else $error("no bank");
  a_off_gap: assert property (p_off_gap) else $error("off too fast");
  a_idle: assert property (p_idle) else $error("no idle drop");
endmodule

bind pin_access_ctrl pin_access_monitor #(
  .IDLE_CYCLES(IDLE_CYCLES),
  .OFF_CYCLES(OFF_CYCLES)
) u_monitor (
  .core_clk(core_clk),
  .rst(rst),
  .symValid(symValid),
  .symbol(symbol),
  .modeLed(modeLed),
  .statusLed(statusLed),
  .controlMode(controlMode),
  .bootDone(bootDone),
  .bankSelect(bankSelect),
  .switchCmd(switchCmd)
);

/* File: testbench/tb.sv */
// self-checking bench for the pin access controller
`timescale 1ns/100ps
`include "pin_access_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import pin_access_pkg::*;
  localparam logic [35:0] IDLE = 36'h0_0000_03E8;
  localparam logic [31:0] OFFC = 32'h0000_0032;
  localparam logic [31:0] BLINKC = 32'h0000_0004;
  logic core_clk, rst, symValid, modeLed, statusLed;
  logic controlMode, bootDone, bankSelect;
  logic [3:0] symbol;
  switch_cmd_t switchCmd;
  switch_cmd_t expQ[$];
  switch_cmd_t exp1;
  int num_errors = 0;
  int n_checks = 0;
  logic ledLast = 1'b0;
  logic sawStatus = 1'b0;
  int dark = 0;
  int keyPulses = 0;
  logic [11:0] seenKey = 12'h000;
  string keyStr;

  pin_access_ctrl #(.IDLE_CYCLES(IDLE), .OFF_CYCLES(OFFC),
    .BLINK_CYCLES(BLINKC)) i_pin_access_ctrl (
    .core_clk(core_clk), .rst(rst), .symValid(symValid), .symbol(symbol),
    .modeLed(modeLed), .statusLed(statusLed), .controlMode(controlMode),
    .bootDone(bootDone), .bankSelect(bankSelect), .switchCmd(switchCmd));
  keypad_model u_keypad (.core_clk(core_clk), .symValid(symValid),
    .symbol(symbol));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic void push(input logic [7:0] h, input logic [7:0] u,
                               input logic o);
    expQ.push_back(switch_cmd_t'({1'b1, h, u, o}));
  endfunction

  // every key digit must lie in 1..5
  function automatic logic key_ok(input logic [11:0] k);
    key_ok = 1'b1;
    for (int i = 0; i < 3; i++)
      if (k[4*i +: 4] < 4'h1 || k[4*i +: 4] > 4'h5)
        key_ok = 1'b0;
  endfunction

  // mode must have settled a few cycles after the enter symbol
  task automatic cmd(input string s, input logic expMode);
    u_keypad.send(s);
    repeat (4) @(posedge core_clk);
    `CHK(controlMode, expMode)
    `CHK(modeLed, expMode)
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // output watcher: every command strobe pops one note; a strobe with no note queued fails
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (switchCmd.valid === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHK(switchCmd, switch_cmd_t'(18'h0_0000))
      end else begin
        exp1 = expQ.pop_front();
        `CHK(switchCmd, exp1)
      end
    end
  end

  // ----------------------------------------
  // key reader: a dark spell of two blink ticks closes a digit
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (statusLed === 1'b1 && bootDone !== 1'b1)
      sawStatus = 1'b1;
    if (bootDone === 1'b1 && controlMode === 1'b0) begin
      if (modeLed === 1'b1 && ledLast !== 1'b1) begin
        keyPulses++;
        dark = 0;
      end else if (modeLed === 1'b0) begin
        dark++;
        if (dark == 2 * BLINKC && keyPulses != 0) begin
          seenKey = {seenKey[7:0], 4'(keyPulses)};
          keyPulses = 0;
        end
      end
      ledLast = modeLed;
    end
  end

  // tests need some 6k cycles; ten times that is the limit
  initial begin
    #1_500_000;
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    for (int u = 9; u <= 16; u++) begin
      push(8'h01, 8'(u), 1'b0);
    end
    push(8'h01, 8'h09, 1'b1);
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 20_000 && bootDone !== 1'b1; i++) begin
      @(posedge core_clk);
    end
    `CHK(bootDone, 1'b1)
    `CHK(bankSelect, 1'b1)
    `CHK(sawStatus, 1'b1)
    $display("test boot finished");

    cmd("*201051#", 1'b0);
    cmd("*12222#", 1'b0);
    cmd("*11111#", 1'b1);
    push(8'h01, 8'h03, 1'b1);
    cmd("*231#", 1'b1);
    push(8'h10, 8'h07, 1'b0);
    cmd("*216070#", 1'b1);
    push(8'h01, 8'h05, 1'b1);
    cmd("*2*201051#", 1'b1);
    $display("test entry and switching finished");

    cmd("*52345#", 1'b1);
    cmd("*62346#", 1'b1);
    cmd("*9#", 1'b0);
    cmd("*12345#", 1'b0);
    cmd("*11111#", 1'b1);
    cmd("*52345#", 1'b1);
    push(8'h01, 8'h03, 1'b1);
    cmd("*231#", 1'b1);
    cmd("*62345#", 1'b1);
    cmd("*9#", 1'b0);
    cmd("*12345#", 1'b0);
    cmd("*11111#", 1'b1);
    cmd("*52345#", 1'b1);
    cmd("*62345#", 1'b1);
    cmd("*9#", 1'b0);
    cmd("*11111#", 1'b0);
    cmd("*12345#", 1'b1);
    $display("test pin change finished");

    repeat (IDLE - 40) @(posedge core_clk);
    `CHK(controlMode, 1'b1)
    repeat (60) @(posedge core_clk);
    `CHK(controlMode, 1'b0)
    `CHK(modeLed, 1'b0)
    cmd("*231#", 1'b0);
    repeat (20) @(posedge core_clk);
    `CHK(expQ.size(), 0)
    $display("test idle timeout finished");

    cmd("*91#", 1'b0);
    u_keypad.send("*911#");
    repeat (300) @(posedge core_clk);
    `CHK(key_ok(seenKey), 1'b1)
    cmd("*91000#", 1'b0);
    cmd("*11111#", 1'b0);
    cmd("*91#", 1'b0);
    u_keypad.send("*911#");
    repeat (300) @(posedge core_clk);
    `CHK(key_ok(seenKey), 1'b1)
    keyStr = $sformatf("*91%0d%0d%0d#", seenKey[11:8], seenKey[7:4],
                       seenKey[3:0]);
    cmd(keyStr, 1'b0);
    cmd("*11111#", 1'b1);
    `CHK(expQ.size(), 0)
    $display("test pin reset finished");
    report_and_stop();
  end
endmodule
